// file: core/pdi2c_map.vh
// constants for the three-port serial host interface block
// assumes a 50 mhz core clock and open-drain pads outside
`ifndef PDI2C_MAP_VH
`define PDI2C_MAP_VH
`define PDI2C_CLK_MHZ        50
// port b fixed addresses, connector one and two
`define PDI2C_B_ADDR_CONN1   7'h38
`define PDI2C_B_ADDR_CONN2   7'h3f
// port a address prefix, low three bits from strap code
`define PDI2C_A_ADDR_PREFIX  4'h4
// default port a strap codes
`define PDI2C_A_CODE_CONN1   3'h0
`define PDI2C_A_CODE_CONN2   3'h1
// master bit timing: standard mode 5 us half period, fast 1.25 us
`define PDI2C_STD_HALF_NS    5000
`define PDI2C_FAST_HALF_NS   1250
`define PDI2C_STD_HALF_CYC   ((`PDI2C_STD_HALF_NS*`PDI2C_CLK_MHZ)/1000)
`define PDI2C_FAST_HALF_CYC  ((`PDI2C_FAST_HALF_NS*`PDI2C_CLK_MHZ)/1000)
// master high time after released clock seen high, 4 us standard
`define PDI2C_STD_HIGH_NS    4000
`define PDI2C_STD_HIGH_CYC   ((`PDI2C_STD_HIGH_NS*`PDI2C_CLK_MHZ+999)/1000)
`define PDI2C_FAST_HIGH_NS   600
`define PDI2C_FAST_HIGH_CYC  ((`PDI2C_FAST_HIGH_NS*`PDI2C_CLK_MHZ+999)/1000)
`define PDI2C_EVT_W          8
`endif

// file: core/pdi2c_target.v
// serial bus target engine: address match, sub-address, byte moves
// assumes scl and sda inputs already synchronised to clk_sys
`timescale 1ns/1ps
`include "pdi2c_map.vh"
module pdi2c_target
(
	// clock and reset
	input  wire       clk_sys,
	input  wire       reset,
	input  wire       clk_en,
	// enable and addresses
	input  wire       enable,
	input  wire [6:0] addr_conn1,
	input  wire [6:0] addr_conn2,
	// synchronised line levels
	input  wire       scl_in,
	input  wire       sda_in,
	// open-drain drive, high means pull low
	output reg        scl_oe,
	output reg        sda_oe,
	// core side
	output reg        conn_sel,
	output reg  [7:0] sub_addr,
	output reg        wr_strobe,
	output reg  [7:0] wr_data,
	output reg        rd_strobe,
	input  wire [7:0] rd_data,
	input  wire       core_busy
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_ACK  = 3'h2;
	localparam ST_RX   = 3'h3;
	localparam ST_TX   = 3'h4;
	localparam ST_RACK = 3'h5;
	reg [2:0] state;
	reg [7:0] shift;
	reg [3:0] bit_cnt;
	reg       scl_d;
	reg       sda_d;
	reg       is_read;
	reg       sub_done;
	reg       stretch;
	wire scl_rise = scl_in & ~scl_d;
	wire scl_fall = ~scl_in & scl_d;
	wire start_c  = scl_in & scl_d & sda_d & ~sda_in;
	wire stop_c   = scl_in & scl_d & ~sda_d & sda_in;
	// byte engine; data sampled only on scl rise so high-phase edges
	// are left to start and stop detection
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			shift <= 8'h00;
			bit_cnt <= 4'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			is_read <= 1'b0;
			sub_done <= 1'b0;
			stretch <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			conn_sel <= 1'b0;
			sub_addr <= 8'h00;
			wr_strobe <= 1'b0;
			wr_data <= 8'h00;
			rd_strobe <= 1'b0;
		end
		else if (clk_en)
		begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
			// hold clock low while the core is not ready
			if (stretch && !core_busy)
			begin
				stretch <= 1'b0;
				scl_oe <= 1'b0;
			end
			if (!enable || stop_c)
			begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
				scl_oe <= 1'b0;
				stretch <= 1'b0;
			end
			else if (start_c)
			begin
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end
			else
			begin
				case (state)
				ST_ADDR, ST_RX:
					if (scl_rise)
					begin
						shift <= {shift[6:0], sda_in};
						bit_cnt <= bit_cnt + 4'h1;
					end
					else if (scl_fall && bit_cnt == 4'h8)
					begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR)
						begin
							if (shift[7:1] == addr_conn1 ||
								shift[7:1] == addr_conn2)
							begin
								conn_sel <= (shift[7:1] == addr_conn2);
								is_read <= shift[0];
								sub_done <= 1'b0;
								sda_oe <= 1'b1;
								state <= ST_ACK;
							end
							else
								state <= ST_IDLE;
						end
						else
						begin
							if (!sub_done)
							begin
								sub_addr <= shift;
								sub_done <= 1'b1;
							end
							else
							begin
								wr_data <= shift;
								wr_strobe <= 1'b1;
							end
							sda_oe <= 1'b1;
							state <= ST_ACK;
						end
						// never hold a bus that addressed someone else
						if (core_busy && (state == ST_RX ||
							shift[7:1] == addr_conn1 ||
							shift[7:1] == addr_conn2))
						begin
							stretch <= 1'b1;
							scl_oe <= 1'b1;
						end
					end
				ST_ACK:
					if (scl_fall)
					begin
						if (is_read)
						begin
							shift <= rd_data;
							rd_strobe <= 1'b1;
							sda_oe <= ~rd_data[7];
							bit_cnt <= 4'h1;
							state <= ST_TX;
						end
						else
						begin
							sda_oe <= 1'b0;
							state <= ST_RX;
						end
					end
				ST_TX:
					if (scl_fall)
					begin
						if (bit_cnt == 4'h8)
						begin
							sda_oe <= 1'b0;
							state <= ST_RACK;
						end
						else
						begin
							sda_oe <= ~shift[7 - bit_cnt[2:0]];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				ST_RACK:
					if (scl_rise)
					begin
						if (sda_in)
							state <= ST_IDLE;
						else
							state <= ST_ACK;
					end
				default:
					state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// file: core/pdi2c_master.v
// serial bus master engine: start, one byte, ack, stop
// assumes scl and sda inputs already synchronised to clk_sys
`timescale 1ns/1ps
`include "pdi2c_map.vh"
module pdi2c_master
(
	// clock and reset
	input  wire       clk_sys,
	input  wire       reset,
	input  wire       clk_en,
	// mode and request
	input  wire       fast_mode,
	input  wire       req,
	input  wire       req_start,
	input  wire       req_stop,
	input  wire [7:0] req_data,
	// synchronised line levels
	input  wire       scl_in,
	input  wire       sda_in,
	// open-drain drive
	output reg        scl_oe,
	output reg        sda_oe,
	// results
	output reg        busy,
	output reg        done,
	output reg        nack,
	output reg        bus_busy
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_LOW   = 3'h2;
	localparam ST_HIGH  = 3'h3;
	localparam ST_STOP  = 3'h4;
	localparam ST_STOP2 = 3'h5;
	reg [2:0]  state;
	reg [8:0]  shift;
	reg [3:0]  bit_cnt;
	reg [11:0] timer;
	reg        scl_d;
	reg        sda_d;
	reg        do_stop;
	// timing counts trimmed to the timer width on purpose
	localparam [31:0] STD_HALF  = `PDI2C_STD_HALF_CYC;
	localparam [31:0] FAST_HALF = `PDI2C_FAST_HALF_CYC;
	localparam [31:0] STD_HIGH  = `PDI2C_STD_HIGH_CYC;
	localparam [31:0] FAST_HIGH = `PDI2C_FAST_HIGH_CYC;
	wire [11:0] half = fast_mode ? FAST_HALF[11:0] : STD_HALF[11:0];
	wire [11:0] high = fast_mode ? FAST_HIGH[11:0] : STD_HIGH[11:0];
	// bus activity tracking so a start is only issued on an idle bus
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			shift <= 9'h000;
			bit_cnt <= 4'h0;
			timer <= 12'h000;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			do_stop <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
			bus_busy <= 1'b0;
		end
		else if (clk_en)
		begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			done <= 1'b0;
			if (scl_in && scl_d && sda_d && !sda_in)
				bus_busy <= 1'b1;
			else if (scl_in && scl_d && !sda_d && sda_in)
				bus_busy <= 1'b0;
			if (timer != 12'h000)
				timer <= timer - 12'h001;
			case (state)
			ST_IDLE:
				if (req && (!req_start || !bus_busy))
				begin
					busy <= 1'b1;
					shift <= {req_data, 1'b1};
					do_stop <= req_stop;
					bit_cnt <= 4'h0;
					timer <= half;
					if (req_start)
					begin
						sda_oe <= 1'b1;
						state <= ST_START;
					end
					else
						state <= ST_LOW;
				end
			ST_START:
				if (timer == 12'h000)
				begin
					scl_oe <= 1'b1;
					timer <= half;
					state <= ST_LOW;
				end
			ST_LOW:
				if (timer == 12'h000)
				begin
					scl_oe <= 1'b0;
					state <= ST_HIGH;
					timer <= high;
				end
				else
				begin
					scl_oe <= 1'b1;
					sda_oe <= ~shift[8];
				end
			ST_HIGH:
				if (!scl_in)
					timer <= high;
				else if (timer == 12'h000)
				begin
					if (bit_cnt == 4'h8)
						nack <= sda_in;
					shift <= {shift[7:0], 1'b1};
					scl_oe <= 1'b1;
					timer <= half;
					if (bit_cnt == 4'h8)
					begin
						if (do_stop)
						begin
							sda_oe <= 1'b1;
							state <= ST_STOP;
						end
						else
						begin
							busy <= 1'b0;
							done <= 1'b1;
							state <= ST_IDLE;
						end
					end
					else
					begin
						bit_cnt <= bit_cnt + 4'h1;
						state <= ST_LOW;
					end
				end
			ST_STOP:
				if (timer == 12'h000)
				begin
					scl_oe <= 1'b0;
					timer <= high;
					state <= ST_STOP2;
				end
			ST_STOP2:
				if (scl_in && timer == 12'h000)
				begin
					sda_oe <= 1'b0;
					busy <= 1'b0;
					done <= 1'b1;
					state <= ST_IDLE;
				end
			default:
				state <= ST_IDLE;
			endcase
		end
	end
endmodule

// file: core/pdi2c_ports.v
// top of the three-port host interface: two targets, two masters, port a switching between roles
// assumes open-drain pads with pull-ups; enables high pull the line low
`timescale 1ns/1ps
`include "pdi2c_map.vh"
module pdi2c_ports
(
	// clock, reset, enable
	input  wire       clk_sys,
	input  wire       reset,
	input  wire       clk_en,
	// port a pins
	input  wire       port_a_serial_clock_in,
	output wire       port_a_serial_clock_out,
	output wire       port_a_serial_clock_oe,
	input  wire       port_a_serial_data_in,
	output wire       port_a_serial_data_out,
	output wire       port_a_serial_data_oe,
	output wire       port_a_interrupt_request_n,
	// port b pins
	input  wire       port_b_serial_clock_in,
	output wire       port_b_serial_clock_out,
	output wire       port_b_serial_clock_oe,
	input  wire       port_b_serial_data_in,
	output wire       port_b_serial_data_out,
	output wire       port_b_serial_data_oe,
	output wire       port_b_interrupt_request_n,
	// port c pins
	input  wire       port_c_serial_clock_in,
	output wire       port_c_serial_clock_out,
	output wire       port_c_serial_clock_oe,
	input  wire       port_c_serial_data_in,
	output wire       port_c_serial_data_out,
	output wire       port_c_serial_data_oe,
	output wire       port_c_interrupt_request_n,
	// configuration
	input  wire       port_a_master_mode,
	input  wire       fast_mode,
	input  wire [2:0] port_a_code_conn1,
	input  wire [2:0] port_a_code_conn2,
	// core events and interrupt masks
	input  wire [7:0] event_set,
	input  wire [7:0] event_clear_a,
	input  wire [7:0] event_clear_b,
	input  wire [7:0] irq_mask_a,
	input  wire [7:0] irq_mask_b,
	input  wire       port_c_irq_event,
	output reg  [7:0] pending_a,
	output reg  [7:0] pending_b,
	// target traffic to the core, port a then port b
	output wire [1:0] tgt_conn_sel,
	output wire [15:0] tgt_sub_addr,
	output wire [1:0] tgt_wr_strobe,
	output wire [15:0] tgt_wr_data,
	output wire [1:0] tgt_rd_strobe,
	input  wire [15:0] tgt_rd_data,
	input  wire [1:0] tgt_core_busy,
	// master requests, 0 is port c, 1 is port a in master mode
	input  wire [1:0] mst_req,
	input  wire [1:0] mst_req_start,
	input  wire [1:0] mst_req_stop,
	input  wire [15:0] mst_req_data,
	output wire [1:0] mst_busy,
	output wire [1:0] mst_done,
	output wire [1:0] mst_nack
);
	// two-flop synchronisers for all six line inputs
	reg  [5:0] sync1;
	reg  [5:0] sync2;
	wire [5:0] raw_in = {port_c_serial_data_in, port_c_serial_clock_in,
		port_b_serial_data_in, port_b_serial_clock_in,
		port_a_serial_data_in, port_a_serial_clock_in};
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			sync1 <= 6'h3f;
			sync2 <= 6'h3f;
		end
		else if (clk_en)
		begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	// port a role; mode input captured so it can change only while the port a master is not busy
	reg        a_master;
	wire [1:0] m_busy_w;
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			a_master <= 1'b0;
		else if (clk_en && !m_busy_w[1])
			a_master <= port_a_master_mode;
	end

	// addresses: port a from strap code, port b fixed
	wire [13:0] t_addr1 = {`PDI2C_B_ADDR_CONN1,
		`PDI2C_A_ADDR_PREFIX, port_a_code_conn1};
	wire [13:0] t_addr2 = {`PDI2C_B_ADDR_CONN2,
		`PDI2C_A_ADDR_PREFIX, port_a_code_conn2};
	wire [1:0] t_en = {1'b1, ~a_master};
	wire [1:0] t_scl_oe;
	wire [1:0] t_sda_oe;
	wire [1:0] m_scl_oe;
	wire [1:0] m_sda_oe;

	// identical target engines on ports a and b
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_tgt
			pdi2c_target u_tgt
			(
				.clk_sys    (clk_sys),
				.reset      (reset),
				.clk_en     (clk_en),
				.enable     (t_en[gi]),
				.addr_conn1 (t_addr1[gi*7 +: 7]),
				.addr_conn2 (t_addr2[gi*7 +: 7]),
				.scl_in     (sync2[gi*2]),
				.sda_in     (sync2[gi*2+1]),
				.scl_oe     (t_scl_oe[gi]),
				.sda_oe     (t_sda_oe[gi]),
				.conn_sel   (tgt_conn_sel[gi]),
				.sub_addr   (tgt_sub_addr[gi*8 +: 8]),
				.wr_strobe  (tgt_wr_strobe[gi]),
				.wr_data    (tgt_wr_data[gi*8 +: 8]),
				.rd_strobe  (tgt_rd_strobe[gi]),
				.rd_data    (tgt_rd_data[gi*8 +: 8]),
				.core_busy  (tgt_core_busy[gi])
			);
		end
	endgenerate

	// master engines: index 0 on port c, index 1 on port a
	wire [1:0] m_scl_in = {sync2[0], sync2[4]};
	wire [1:0] m_sda_in = {sync2[1], sync2[5]};
	wire [1:0] m_req_ok = {mst_req[1] & a_master, mst_req[0]};
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_mst
			pdi2c_master u_mst
			(
				.clk_sys   (clk_sys),
				.reset     (reset),
				.clk_en    (clk_en),
				.fast_mode (fast_mode),
				.req       (m_req_ok[gi]),
				.req_start (mst_req_start[gi]),
				.req_stop  (mst_req_stop[gi]),
				.req_data  (mst_req_data[gi*8 +: 8]),
				.scl_in    (m_scl_in[gi]),
				.sda_in    (m_sda_in[gi]),
				.scl_oe    (m_scl_oe[gi]),
				.sda_oe    (m_sda_oe[gi]),
				.busy      (m_busy_w[gi]),
				.done      (mst_done[gi]),
				.nack      (mst_nack[gi]),
				.bus_busy  ()
			);
		end
	endgenerate
	assign mst_busy = m_busy_w;

	// pad drive; port b has no master so it never starts a transfer
	assign port_a_serial_clock_oe = a_master ? m_scl_oe[1] : t_scl_oe[0];
	assign port_a_serial_data_oe  = a_master ? m_sda_oe[1] : t_sda_oe[0];
	assign port_b_serial_clock_oe = t_scl_oe[1];
	assign port_b_serial_data_oe  = t_sda_oe[1];
	assign port_c_serial_clock_oe = m_scl_oe[0];
	assign port_c_serial_data_oe  = m_sda_oe[0];
	assign port_a_serial_clock_out = 1'b0;
	assign port_a_serial_data_out  = 1'b0;
	assign port_b_serial_clock_out = 1'b0;
	assign port_b_serial_data_out  = 1'b0;
	assign port_c_serial_clock_out = 1'b0;
	assign port_c_serial_data_out  = 1'b0;

	// sticky event flags per target port; a new set beats a clear
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			pending_a <= 8'h00;
			pending_b <= 8'h00;
		end
		else if (clk_en)
		begin
			pending_a <= (pending_a & ~event_clear_a) | event_set;
			pending_b <= (pending_b & ~event_clear_b) | event_set;
		end
	end

	// interrupt outputs registered, open-drain style active low
	reg irq_a;
	reg irq_b;
	reg irq_c;
	always @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			irq_a <= 1'b0;
			irq_b <= 1'b0;
			irq_c <= 1'b0;
		end
		else if (clk_en)
		begin
			irq_a <= |(pending_a & irq_mask_a);
			irq_b <= |(pending_b & irq_mask_b);
			irq_c <= port_c_irq_event;
		end
	end
	assign port_a_interrupt_request_n = ~irq_a;
	assign port_b_interrupt_request_n = ~irq_b;
	assign port_c_interrupt_request_n = ~irq_c;
endmodule

// file: sim/pdi2c_ports_props.sv
// assertion checker for the three-port host interface top
// assumes pad inputs carry the resolved open-drain wire levels
`timescale 1ns/1ps
module pdi2c_ports_props
(
	// clock and reset
	input logic       clk_sys,
	input logic       reset,
	// port b and port c pads
	input logic       port_b_serial_clock_in,
	input logic       port_b_serial_clock_oe,
	input logic       port_b_serial_data_oe,
	input logic       port_c_serial_clock_oe,
	input logic       port_c_serial_data_oe,
	// interrupts and masks
	input logic       port_a_interrupt_request_n,
	input logic       port_b_interrupt_request_n,
	input logic [7:0] pending_a,
	input logic [7:0] pending_b,
	input logic [7:0] irq_mask_a,
	input logic [7:0] irq_mask_b,
	// master status
	input logic [1:0] mst_busy,
	input logic [1:0] mst_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// irq follows the masked pending set; three cycles cover register lag
	a_irq_a_on: assert property (
		(|(pending_a & irq_mask_a)) [*3] |-> !port_a_interrupt_request_n)
		else $error("port a irq not raised");
	a_irq_a_off: assert property (
		(!(|(pending_a & irq_mask_a))) [*3] |-> port_a_interrupt_request_n)
		else $error("port a irq not released");
	a_irq_b_on: assert property (
		(|(pending_b & irq_mask_b)) [*3] |-> !port_b_interrupt_request_n)
		else $error("port b irq not raised");
	a_irq_b_off: assert property (
		(!(|(pending_b & irq_mask_b))) [*3] |-> port_b_interrupt_request_n)
		else $error("port b irq not released");
	// target data only moves while the clock is low
	a_sda_stable: assert property (
		$changed(port_b_serial_data_oe) |-> !port_b_serial_clock_in)
		else $error("port b data moved with clock high");
	// a target only holds a clock that the host already pulled low
	a_b_no_drive: assert property (
		$rose(port_b_serial_clock_oe) |-> !port_b_serial_clock_in)
		else $error("port b pulled a high clock");
	a_c_idle_free: assert property (
		!mst_busy[0] [*2] |-> !port_c_serial_clock_oe && !port_c_serial_data_oe)
		else $error("port c lines held while idle");
	// nine bit periods cannot finish within eight cycles
	a_c_no_early: assert property (
		$rose(mst_busy[0]) |-> !mst_done[0] [*8])
		else $error("port c done too early");
endmodule
bind pdi2c_ports pdi2c_ports_props u_props (.*);

// file: sim/pdi2c_host_model.sv
// behavioural bus host for one target port, 160 ns bit period
// assumes a pulled-up wire; oe high pulls the line low
`timescale 1ns/1ps
module pdi2c_host_model
(
	// resolved wire levels
	input  wire scl,
	input  wire sda,
	// open-drain drives
	output reg  scl_oe,
	output reg  sda_oe
);
	// released lines float high on the pull-ups, never a stale level
	initial
	begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// one bit; waits out any stretch before timing the high phase
	task xbit(input b, output r);
		reg s;
		begin
			#20 sda_oe = ~b;
			#60 scl_oe = 1'b0;
			#1 s = scl;
			wait (scl === 1'b1);
			// a stretched clock earns the full standard-mode high time
			if (s !== 1'b1)
				#4000;
			#79 r = sda;
			scl_oe = 1'b1;
		end
	endtask
	// start or repeated start, only called on an idle bus or after ack
	task start;
		begin
			#20 sda_oe = 1'b0;
			#60 scl_oe = 1'b0;
			wait (scl === 1'b1);
			#80 sda_oe = 1'b1;
			#80 scl_oe = 1'b1;
		end
	endtask
	task stop;
		begin
			#20 sda_oe = 1'b1;
			#60 scl_oe = 1'b0;
			wait (scl === 1'b1);
			#80 sda_oe = 1'b0;
			#80;
		end
	endtask
	task wbyte(input [7:0] d, output a);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
				xbit(d[i], a);
			xbit(1'b1, a);
		end
	endtask
	task rbyte(input nak, output [7:0] d);
		integer i;
		reg     r;
		begin
			for (i = 0; i < 8; i = i + 1)
			begin
				xbit(1'b1, r);
				d = {d[6:0], r};
			end
			xbit(nak, r);
		end
	endtask
	task wr_txn(input [6:0] a, input [7:0] s, input [7:0] v, output [2:0] k);
		begin
			start;
			wbyte({a, 1'b0}, k[2]);
			wbyte(s, k[1]);
			wbyte(v, k[0]);
			stop;
		end
	endtask
	task rd_txn(input [6:0] a, input [7:0] s, output [7:0] d, output [2:0] k);
		begin
			start;
			wbyte({a, 1'b0}, k[2]);
			wbyte(s, k[1]);
			start;
			wbyte({a, 1'b1}, k[0]);
			rbyte(1'b1, d);
			stop;
		end
	endtask
endmodule

// file: sim/tb_pdi2c_ports.sv
// self-checking bench for the three-port host interface
// assumes pull-ups on all pads; host models sit on ports a and b
`timescale 1ns/1ps
`include "pdi2c_map.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
	err_total = err_total + 1; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_pdi2c_ports;
	// stimulus and configuration
	reg         clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, c_ack = 1'b0;
	reg         port_a_master_mode = 1'b0, fast_mode = 1'b0;
	reg         port_c_irq_event = 1'b0;
	reg  [2:0]  port_a_code_conn1 = 3'h0, port_a_code_conn2 = 3'h1;
	reg  [7:0]  event_set = 8'h00, event_clear_a = 8'h00, cap = 8'h00;
	reg  [7:0]  event_clear_b = 8'h00, irq_mask_a = 8'h00;
	reg  [7:0]  irq_mask_b = 8'h00;
	reg  [15:0] tgt_rd_data = 16'ha695, mst_req_data = 16'h0000;
	reg  [1:0]  tgt_core_busy = 2'h0, mst_req = 2'h0;
	reg  [1:0]  mst_req_start = 2'h0, mst_req_stop = 2'h0;
	integer     err_total = 0, n_tests = 0, nbit = 9, nstb = 0, nrd = 0;
	// design outputs and host drives
	wire        port_a_serial_clock_out, port_a_serial_clock_oe;
	wire        port_a_serial_data_out, port_a_serial_data_oe;
	wire        port_b_serial_clock_out, port_b_serial_clock_oe;
	wire        port_b_serial_data_out, port_b_serial_data_oe;
	wire        port_c_serial_clock_out, port_c_serial_clock_oe;
	wire        port_c_serial_data_out, port_c_serial_data_oe;
	wire        port_a_interrupt_request_n, port_b_interrupt_request_n;
	wire        port_c_interrupt_request_n, ha_scl, ha_sda, hb_scl, hb_sda;
	wire [7:0]  pending_a, pending_b;
	wire [1:0]  tgt_conn_sel, tgt_wr_strobe, tgt_rd_strobe;
	wire [1:0]  mst_busy, mst_done, mst_nack;
	wire [15:0] tgt_sub_addr, tgt_wr_data;
	wire [5:0]  pad_out = {port_a_serial_clock_out, port_a_serial_data_out,
		port_b_serial_clock_out, port_b_serial_data_out,
		port_c_serial_clock_out, port_c_serial_data_out};
	// wired-and pads: low whenever any party pulls
	wire port_a_serial_clock_in = ~(port_a_serial_clock_oe | ha_scl);
	wire port_a_serial_data_in = ~(port_a_serial_data_oe | ha_sda);
	wire port_b_serial_clock_in = ~(port_b_serial_clock_oe | hb_scl);
	wire port_b_serial_data_in = ~(port_b_serial_data_oe | hb_sda);
	wire port_c_serial_clock_in = ~port_c_serial_clock_oe;
	wire port_c_serial_data_in = ~(port_c_serial_data_oe | c_ack);
	pdi2c_ports dut (.*);
	pdi2c_host_model ha (.scl(port_a_serial_clock_in),
		.sda(port_a_serial_data_in), .scl_oe(ha_scl), .sda_oe(ha_sda));
	pdi2c_host_model hb (.scl(port_b_serial_clock_in),
		.sda(port_b_serial_data_in), .scl_oe(hb_scl), .sda_oe(hb_sda));
	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end
	// strobe counter; a missed or doubled strobe shows in the count
	always @(posedge clk_sys) nstb <= nstb + tgt_wr_strobe[0] + tgt_wr_strobe[1];
	always @(posedge clk_sys) nrd <= nrd + tgt_rd_strobe[1];
	// tiny port c target: grabs eight bits, acks the ninth clock
	always @(negedge port_c_serial_data_in) if (port_c_serial_clock_in) nbit = 0;
	always @(posedge port_c_serial_clock_in)
	begin
		if (nbit < 8) cap = {cap[6:0], port_c_serial_data_in};
		nbit = nbit + 1;
	end
	always @(negedge port_c_serial_clock_in) c_ack <= (nbit == 8);
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// holds the request until taken, then waits a bounded time for done
	task wait_done(input integer i, output integer c);
		begin
			c = 0;
			while (mst_done[i] !== 1'b1 && c < 20000)
			begin
				@(negedge clk_sys);
				if (mst_busy[i] === 1'b1) mst_req[i] = 1'b0;
				c = c + 1;
			end
			if (c >= 20000) err_total = err_total + 1;
		end
	endtask
	task t_write_a;
		reg [2:0] k;
		begin
			ha.wr_txn({`PDI2C_A_ADDR_PREFIX, port_a_code_conn2}, 8'h6b, 8'h3d, k);
			`CHK(k, 3'b000)
			`CHK(tgt_conn_sel[0], 1'b1)
			`CHK(tgt_sub_addr[7:0], 8'h6b)
			`CHK(tgt_wr_data[7:0], 8'h3d)
			ha.wr_txn({`PDI2C_A_ADDR_PREFIX, port_a_code_conn1}, 8'h12, 8'h34, k);
			`CHK(k, 3'b000)
			`CHK(tgt_conn_sel[0], 1'b0)
			$display("test write_a done");
		end
	endtask
	task t_write_b;
		reg [2:0] k;
		integer   n0;
		begin
			n0 = nstb;
			hb.wr_txn(`PDI2C_B_ADDR_CONN1, 8'h5a, 8'hc3, k);
			`CHK(k, 3'b000)
			`CHK(nstb - n0, 1)
			`CHK(tgt_conn_sel[1], 1'b0)
			`CHK(tgt_wr_data[15:8], 8'hc3)
			hb.wr_txn({`PDI2C_A_ADDR_PREFIX, 3'h0}, 8'h77, 8'h01, k);
			`CHK(k[2], 1'b1)
			`CHK(tgt_sub_addr[15:8], 8'h5a)
			$display("test write_b done");
		end
	endtask
	task t_read_b;
		reg [2:0] k;
		reg [7:0] d;
		integer   n0;
		begin
			n0 = nrd;
			hb.rd_txn(`PDI2C_B_ADDR_CONN2, 8'h21, d, k);
			`CHK(k, 3'b000)
			`CHK(nrd - n0, 1)
			`CHK(d, tgt_rd_data[15:8])
			`CHK(tgt_conn_sel[1], 1'b1)
			`CHK(tgt_sub_addr[15:8], 8'h21)
			`CHK(port_b_serial_data_oe, 1'b0)
			$display("test read_b done");
		end
	endtask
	task t_stretch_b;
		reg [2:0] k;
		begin
			tgt_core_busy[1] = 1'b1;
			fork
				hb.wr_txn(`PDI2C_B_ADDR_CONN1, 8'h11, 8'h22, k);
				begin
					repeat (600) @(negedge clk_sys);
					`CHK(port_b_serial_clock_in, 1'b0)
					tgt_core_busy[1] = 1'b0;
				end
			join
			`CHK(k, 3'b000)
			`CHK(tgt_wr_data[15:8], 8'h22)
			$display("test stretch_b done");
		end
	endtask
	task t_irq;
		begin
			clk_en = 1'b0;
			event_set = 8'h01;
			repeat (2) @(negedge clk_sys);
			`CHK(pending_a, 8'h00)
			event_set = 8'h00;
			clk_en = 1'b1;
			irq_mask_a = 8'h04;
			event_set = 8'h04;
			port_c_irq_event = 1'b1;
			@(negedge clk_sys);
			event_set = 8'h00;
			repeat (4) @(negedge clk_sys);
			`CHK(port_a_interrupt_request_n, 1'b0)
			`CHK(port_b_interrupt_request_n, 1'b1)
			`CHK(port_c_interrupt_request_n, 1'b0)
			event_clear_a = 8'h04;
			irq_mask_b = 8'h04;
			@(negedge clk_sys);
			event_clear_a = 8'h00;
			repeat (4) @(negedge clk_sys);
			`CHK(port_a_interrupt_request_n, 1'b1)
			`CHK(port_b_interrupt_request_n, 1'b0)
			event_clear_b = 8'h04;
			event_set = 8'h10;
			@(negedge clk_sys);
			{event_clear_b, event_set} = 16'h0000;
			repeat (4) @(negedge clk_sys);
			`CHK(pending_b, 8'h10)
			`CHK(port_b_interrupt_request_n, 1'b1)
			$display("test irq done");
		end
	endtask
	task t_master_c;
		integer m, c;
		begin
			for (m = 0; m < 2; m = m + 1)
			begin
				fast_mode = m[0];
				mst_req_data[7:0] = 8'ha5 ^ m[7:0];
				{mst_req_start[0], mst_req_stop[0], mst_req[0]} = 3'b111;
				wait_done(0, c);
				`CHK(cap, 8'ha5 ^ m[7:0])
				`CHK(mst_nack[0], 1'b0)
				`CHK(c > 3000, !m[0])
				@(negedge clk_sys);
				`CHK(port_c_serial_data_in, 1'b1)
			end
			$display("test master_c done");
		end
	endtask
	task t_role_a;
		reg [2:0] k;
		integer   c;
		begin
			port_a_master_mode = 1'b1;
			repeat (4) @(negedge clk_sys);
			ha.wr_txn({`PDI2C_A_ADDR_PREFIX, port_a_code_conn2}, 8'h01, 8'h02, k);
			`CHK(k, 3'b111)
			mst_req_data[15:8] = 8'h3c;
			{mst_req_start[1], mst_req_stop[1], mst_req[1]} = 3'b111;
			wait_done(1, c);
			`CHK(mst_nack[1], 1'b1)
			`CHK(pad_out, 6'h00)
			port_a_master_mode = 1'b0;
			$display("test role_a done");
		end
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		repeat (3) @(negedge clk_sys);
		t_write_a;
		t_write_b;
		t_read_b;
		t_stretch_b;
		t_irq;
		t_master_c;
		t_role_a;
		end_sim;
	end
	// watchdog: the whole run needs well under a millisecond
	initial
	begin
		#1000000;
		err_total = err_total + 1;
		$display("watchdog expired");
		end_sim;
	end
endmodule
